// ===== verilog/alu_params.svh
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define ALU_DATA_W 8
`define ALU_ADDR_W 7
`define ALU_BITSEL_W 3
`define ALU_NIBBLE_MSB 3
`define ALU_DEST_ACC 1'b0
`define ALU_DEST_REG 1'b1
`define ALU_ACC_RESET 8'h00
`define ALU_ZERO_BYTE 8'h00
`endif

// ===== verilog/alu_pkg.sv
package alu_pkg;
	typedef enum logic [2:0] {
		op_none = 3'h0,
		add_literal_to_acc = 3'h1,
		add_acc_to_reg = 3'h3,
		and_acc_with_reg = 3'h2,
		and_literal_to_acc = 3'h6,
		reg_bit_clear_op = 3'h7,
		reg_bit_set_op = 3'h5
	} op_e;
	typedef struct packed {
		op_e op;
		logic [7:0] literal;
		logic [6:0] addr;
		logic [2:0] bit_sel;
		logic dest;
	} instr_s;
	typedef struct packed {
		logic carry;
		logic nibble_carry_bit;
		logic zero;
	} flags_s;
endpackage

// ===== verilog/alu_add_and_bit_ops.sv
`timescale 1ns/1ps
`include "alu_params.svh"
// Summary of operation
// RULE_01: Add literal to accumulator; result to accumulator; update carry, nibble carry, zero.
// RULE_02: Add accumulator and addressed register; update carry, nibble carry, zero.
// RULE_03: AND accumulator with addressed register; only zero flag changes.
// RULE_04: AND literal with accumulator into accumulator; only zero flag changes.
// RULE_05: Bit clear forces selected bit of addressed register to zero; flags unchanged.
// RULE_06: Bit set forces selected bit of addressed register to one; flags unchanged.
// RULE_07: Register add/AND: destination 0 writes accumulator, 1 writes register back.
// RULE_08: Bit set/clear rewrite whole byte, keeping all other bits.
module alu_add_and_bit_ops #(
	parameter int DATA_W = `ALU_DATA_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire alu_pkg::instr_s instr,
	input wire logic [DATA_W-1:0] reg_rd_data,
	output logic [`ALU_ADDR_W-1:0] reg_rd_addr,
	output logic reg_wr_en,
	output logic [`ALU_ADDR_W-1:0] reg_wr_addr,
	output logic [DATA_W-1:0] reg_wr_data,
	output logic [DATA_W-1:0] acc,
	output alu_pkg::flags_s flags
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [DATA_W:0] add_full(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		add_full = {1'b0, a} + {1'b0, b};
	endfunction

	function automatic logic nibble_cy(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		logic [`ALU_NIBBLE_MSB+1:0] s;
		s = {1'b0, a[`ALU_NIBBLE_MSB:0]} + {1'b0, b[`ALU_NIBBLE_MSB:0]};
		nibble_cy = s[`ALU_NIBBLE_MSB+1];
	endfunction

	// ****************************************
	// Datapath
	// ****************************************
	// Register read is combinational: address follows the instruction in the same cycle
	logic [DATA_W-1:0] acc_reg, acc_next;
	alu_pkg::flags_s flags_reg, flags_next;
	logic wr_en_reg, wr_en_next;
	logic [`ALU_ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic [DATA_W-1:0] wr_data_reg, wr_data_next;
	logic [DATA_W:0] sum;
	logic [DATA_W-1:0] operand, result, bit_mask;

	assign reg_rd_addr = instr.addr;

	always_comb begin
		acc_next = acc_reg;
		flags_next = flags_reg;
		wr_en_next = 1'b0;
		wr_addr_next = instr.addr;
		wr_data_next = wr_data_reg;
		operand = (instr.op == alu_pkg::add_literal_to_acc || instr.op == alu_pkg::and_literal_to_acc)
			? instr.literal : reg_rd_data;
		sum = add_full(acc_reg, operand);
		result = operand;
		bit_mask = DATA_W'(1) << instr.bit_sel;
		if (instr_valid) begin
			unique case (instr.op)
				alu_pkg::add_literal_to_acc, alu_pkg::add_acc_to_reg: begin
					result = sum[DATA_W-1:0];
					flags_next.carry = sum[DATA_W]; // RULE_01 RULE_02
					flags_next.nibble_carry_bit = nibble_cy(acc_reg, operand); // RULE_01 RULE_02
					flags_next.zero = (result == `ALU_ZERO_BYTE); // RULE_01 RULE_02
				end
				alu_pkg::and_literal_to_acc, alu_pkg::and_acc_with_reg: begin
					result = acc_reg & operand;
					flags_next.zero = (result == `ALU_ZERO_BYTE); // RULE_03 RULE_04
				end
				alu_pkg::reg_bit_clear_op: begin
					result = reg_rd_data & ~bit_mask; // RULE_05 RULE_08
				end
				alu_pkg::reg_bit_set_op: begin
					result = reg_rd_data | bit_mask; // RULE_06 RULE_08
				end
				alu_pkg::op_none: begin
					result = operand;
				end
				// Unused op code from a faulty decoder acts as no operation
				default: begin
					result = operand;
				end
			endcase
			unique case (instr.op)
				alu_pkg::add_literal_to_acc, alu_pkg::and_literal_to_acc: begin
					acc_next = result; // RULE_01 RULE_04
				end
				alu_pkg::add_acc_to_reg, alu_pkg::and_acc_with_reg: begin
					// Destination bit picks accumulator or register write-back
					if (instr.dest == `ALU_DEST_ACC) begin
						acc_next = result; // RULE_07
					end else begin
						wr_en_next = 1'b1; // RULE_07
						wr_data_next = result;
					end
				end
				alu_pkg::reg_bit_clear_op, alu_pkg::reg_bit_set_op: begin
					wr_en_next = 1'b1; // RULE_08
					wr_data_next = result;
				end
				alu_pkg::op_none: begin
					wr_en_next = 1'b0;
				end
				default: begin
					wr_en_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= `ALU_ACC_RESET;
			flags_reg <= '0;
			wr_en_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			flags_reg <= flags_next;
			wr_en_reg <= wr_en_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
		end
	end

	assign acc = acc_reg;
	assign flags = flags_reg;
	assign reg_wr_en = wr_en_reg;
	assign reg_wr_addr = wr_addr_reg;
	assign reg_wr_data = wr_data_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence bit_op_issued;
		instr_valid && (instr.op == alu_pkg::reg_bit_set_op || instr.op == alu_pkg::reg_bit_clear_op);
	endsequence

	AST_ADDL_RESULT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		instr_valid && instr.op == alu_pkg::add_literal_to_acc
		|=> acc == DATA_W'(($past(acc) + $past(instr.literal))) && flags.carry == $past(sum[DATA_W]))
		else $error("add literal result wrong");
	AST_ADDR_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		instr_valid && instr.op == alu_pkg::add_acc_to_reg
		|=> flags.zero == ($past(sum[DATA_W-1:0]) == `ALU_ZERO_BYTE)
		&& flags.nibble_carry_bit == $past(nibble_cy(acc_reg, reg_rd_data)))
		else $error("add register flags wrong");
	AST_ANDR_CARRY_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		instr_valid && instr.op == alu_pkg::and_acc_with_reg
		|=> $stable(flags.carry) && $stable(flags.nibble_carry_bit))
		else $error("and register touched carry");
	AST_ANDL_RESULT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		instr_valid && instr.op == alu_pkg::and_literal_to_acc
		|=> acc == ($past(acc) & $past(instr.literal)) && $stable(flags.carry))
		else $error("and literal result wrong");
	AST_BCF_BIT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
		instr_valid && instr.op == alu_pkg::reg_bit_clear_op
		|=> reg_wr_en && !reg_wr_data[$past(instr.bit_sel)])
		else $error("bit clear not applied");
	AST_BSF_BIT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		instr_valid && instr.op == alu_pkg::reg_bit_set_op
		|=> reg_wr_en && reg_wr_data[$past(instr.bit_sel)])
		else $error("bit set not applied");
	AST_DEST_SEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		instr_valid && (instr.op == alu_pkg::add_acc_to_reg || instr.op == alu_pkg::and_acc_with_reg)
		|=> reg_wr_en == $past(instr.dest)
		&& (reg_wr_en ? ($stable(acc) && reg_wr_data == $past(result)) : acc == $past(result)))
		else $error("destination select wrong");
	AST_BIT_RMW: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		bit_op_issued
		|=> ((reg_wr_data ^ $past(reg_rd_data)) & ~$past(bit_mask)) == `ALU_ZERO_BYTE && $stable(flags)
		&& $stable(acc))
		else $error("bit op disturbed other bits");

	// ****************************************
	// Further checks
	// ****************************************
	// Write strobe is a single pulse; a stuck strobe would corrupt memory
	sequence lit_op_issued;
		instr_valid && (instr.op == alu_pkg::add_literal_to_acc || instr.op == alu_pkg::and_literal_to_acc);
	endsequence

	sequence reg_wb_issued;
		instr_valid && instr.dest == `ALU_DEST_REG
		&& (instr.op == alu_pkg::add_acc_to_reg || instr.op == alu_pkg::and_acc_with_reg);
	endsequence

	sequence idle_slot;
		!instr_valid;
	endsequence

	AST_ADDL_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		instr_valid && instr.op == alu_pkg::add_literal_to_acc
		|=> flags.nibble_carry_bit == $past(nibble_cy(acc_reg, instr.literal))
		&& flags.zero == (acc == `ALU_ZERO_BYTE))
		else $error("add literal flags wrong");
	AST_LIT_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		lit_op_issued |=> !reg_wr_en)
		else $error("literal op wrote a register");
	AST_ADDR_RESULT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		instr_valid && instr.op == alu_pkg::add_acc_to_reg
		|=> flags.carry == $past(sum[DATA_W])
		&& (reg_wr_en ? reg_wr_data : acc) == $past(sum[DATA_W-1:0]))
		else $error("add register result wrong");
	AST_ANDR_RESULT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		instr_valid && instr.op == alu_pkg::and_acc_with_reg
		|=> (reg_wr_en ? reg_wr_data : acc) == ($past(acc_reg) & $past(reg_rd_data))
		&& flags.zero == (($past(acc_reg) & $past(reg_rd_data)) == `ALU_ZERO_BYTE))
		else $error("and register result wrong");
	AST_ANDL_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		instr_valid && instr.op == alu_pkg::and_literal_to_acc
		|=> flags.zero == (acc == `ALU_ZERO_BYTE) && $stable(flags.nibble_carry_bit))
		else $error("and literal zero flag wrong");
	AST_BCF_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
		instr_valid && instr.op == alu_pkg::reg_bit_clear_op
		|=> $stable(flags) && reg_wr_addr == $past(instr.addr))
		else $error("bit clear touched flags or address");
	AST_BSF_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		instr_valid && instr.op == alu_pkg::reg_bit_set_op
		|=> $stable(flags) && reg_wr_addr == $past(instr.addr))
		else $error("bit set touched flags or address");
	AST_DEST_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		reg_wb_issued |=> reg_wr_en && reg_wr_addr == $past(instr.addr) && $stable(acc))
		else $error("register write-back address wrong");
	AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		idle_slot |=> $stable(acc) && $stable(flags) && !reg_wr_en)
		else $error("state changed without instruction");
	AST_BIT_WR_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		bit_op_issued ##1 idle_slot |=> !reg_wr_en)
		else $error("bit op write strobe stuck");
endmodule

// ===== bench/alu_add_and_bit_ops_bench.sv
`timescale 1ns/1ps
module alu_add_and_bit_ops_bench;
	// ****************
	// Stimulus and memory model
	// ****************
	logic clk, rst_n, instr_valid, reg_wr_en;
	alu_pkg::instr_s instr;
	alu_pkg::flags_s flags, ef;
	logic [7:0] reg_rd_data, reg_wr_data, acc, ea;
	logic [6:0] reg_rd_addr, reg_wr_addr;
	logic [7:0] mem [128];
	logic [7:0] em [128];
	int n_mismatch = 0;
	int n_tests = 0;
	alu_add_and_bit_ops dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
		.reg_rd_data(reg_rd_data), .reg_rd_addr(reg_rd_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .acc(acc), .flags(flags));
	// Write lands at the edge that ends the strobe cycle, so a back-to-back read still sees the old byte
	assign reg_rd_data = mem[reg_rd_addr];
	always @(posedge clk) begin
		if (reg_wr_en === 1'b1) mem[reg_wr_addr] <= reg_wr_data;
	end
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_op(alu_pkg::op_e o, logic [7:0] l, logic [6:0] a, logic [2:0] b, logic d);
		logic [8:0] s;
		logic [7:0] v, r;
		logic w;
		v = (o == alu_pkg::add_literal_to_acc || o == alu_pkg::and_literal_to_acc) ? l : em[a];
		s = {1'b0, ea} + {1'b0, v};
		w = 0;
		r = ea;
		case (o)
			alu_pkg::add_literal_to_acc, alu_pkg::add_acc_to_reg: begin
				r = s[7:0];
				ef.carry = s[8];
				ef.nibble_carry_bit = ({1'b0, ea[3:0]} + {1'b0, v[3:0]}) > 5'h0f;
				ef.zero = (r == 8'h00);
			end
			alu_pkg::and_literal_to_acc, alu_pkg::and_acc_with_reg: begin
				r = ea & v;
				ef.zero = (r == 8'h00);
			end
			alu_pkg::reg_bit_clear_op: begin
				r = em[a] & ~(8'h01 << b);
				w = 1;
			end
			alu_pkg::reg_bit_set_op: begin
				r = em[a] | (8'h01 << b);
				w = 1;
			end
			default: ;
		endcase
		if (o == alu_pkg::add_acc_to_reg || o == alu_pkg::and_acc_with_reg) w = d;
		if (w) em[a] = r;
		else ea = r;
		@(posedge clk);
		instr_valid <= 1;
		instr <= '{op: o, literal: l, addr: a, bit_sel: b, dest: d};
		#1;
		chk("reg_rd_addr", {1'b0, a}, {1'b0, reg_rd_addr});
		@(posedge clk);
		instr_valid <= 0;
		#1;
		chk("acc", ea, acc);
		chk("flags", {5'h00, ef}, {5'h00, flags});
		chk("reg_wr_en", {7'h00, w}, {7'h00, reg_wr_en});
		if (w) chk("reg_wr_addr", {1'b0, a}, {1'b0, reg_wr_addr});
		if (w) chk("reg_wr_data", r, reg_wr_data);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_add_lit;
		do_op(alu_pkg::add_literal_to_acc, 8'h8f, 7'h00, 3'h0, 1'b0);
		do_op(alu_pkg::add_literal_to_acc, 8'h71, 7'h00, 3'h0, 1'b0);
		do_op(alu_pkg::op_none, 8'hff, 7'h00, 3'h0, 1'b1);
		do_op(alu_pkg::add_literal_to_acc, 8'hff, 7'h00, 3'h0, 1'b0);
	endtask
	task automatic t_add_reg;
		do_op(alu_pkg::add_acc_to_reg, 8'h00, 7'h00, 3'h0, 1'b0);
		do_op(alu_pkg::add_acc_to_reg, 8'h00, 7'h7f, 3'h0, 1'b1);
		do_op(alu_pkg::add_acc_to_reg, 8'h00, 7'h7f, 3'h0, 1'b0);
		do_op(alu_pkg::add_literal_to_acc, 8'hff, 7'h00, 3'h0, 1'b0);
	endtask
	task automatic t_and;
		do_op(alu_pkg::and_literal_to_acc, 8'hff, 7'h00, 3'h0, 1'b0);
		do_op(alu_pkg::and_acc_with_reg, 8'h00, 7'h40, 3'h0, 1'b1);
		do_op(alu_pkg::and_acc_with_reg, 8'h00, 7'h41, 3'h0, 1'b0);
		do_op(alu_pkg::and_literal_to_acc, 8'h00, 7'h00, 3'h0, 1'b0);
	endtask
	task automatic t_bits;
		for (int i = 0; i < 8; i++) begin
			do_op(alu_pkg::reg_bit_set_op, 8'h00, 7'h7f, i[2:0], 1'b0);
			do_op(alu_pkg::reg_bit_clear_op, 8'h00, 7'h00, i[2:0], 1'b1);
		end
	endtask
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37) ^ 8'h5a;
		em = mem;
		ea = 8'h00;
		ef = '0;
		rst_n = 0;
		instr_valid = 0;
		instr = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1;
		#1;
		chk("acc", 8'h00, acc);
		chk("flags", 8'h00, {5'h00, flags});
		t_add_lit();
		t_add_reg();
		t_and();
		t_bits();
		wrap_up();
	end
	// Generous span; the full sequence needs well under 200 cycles
	initial begin
		repeat (2000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
endmodule
